// File: gpio_port.sv
/*
 * Eight-pin general purpose port with external interrupt group,
 * peripheral alternate functions, analog channel routing and a
 * USB transmit-enable override on pin 0, behind an AHB-Lite slave.
 * Assumes a single AHB-Lite master, pads resolved outside from
 * out/oe, and peripherals that drive their own alternate requests.
 */
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_map.svh"

////////////////////////////////////////////////////////////////////////////
module gpio_port (
   input  wire logic                 mclk,
   input  wire logic                 sys_rst,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire gpio_port_pkg::byte_t pad_in,
   output gpio_port_pkg::byte_t      pad_out,
   output gpio_port_pkg::byte_t      pad_oe,
   input  wire gpio_port_pkg::byte_t alt_out_en,
   input  wire gpio_port_pkg::byte_t alt_out,
   input  wire gpio_port_pkg::byte_t alt_open_drain,
   input  wire logic                 usb_tx_active,
   output gpio_port_pkg::byte_t      pin_level,
   output gpio_port_pkg::byte_t      analog_switch,
   output logic                      ext_irq_request
);
   import gpio_port_pkg::*;

   port_state_t st_reg;
   port_state_t st_next;
   byte_t       pins_sync;
   byte_t       out_mode;
   logic [3:0]  irq_en_eff;
   logic        take;

   function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] ofs);
      addr_hit = (a == ofs);
   endfunction

   function automatic logic [31:0] read_value(input logic [7:0] a,
                                              input port_state_t s,
                                              input byte_t pins);
      logic [31:0] v;
      v = 32'h0000_0000;
      if (addr_hit(a, `PORT_DATA_LATCH_OFS)) begin
         v[7:0] = (s.dir & s.latch) | (~s.dir & pins);
      end
      if (addr_hit(a, `PORT_DIRECTION_OFS)) begin
         v[7:0] = s.dir;
      end
      if (addr_hit(a, `EXT_IRQ_ENABLE1_OFS)) begin
         v[3:0] = s.irq_en;
      end
      if (addr_hit(a, `MISC_CTRL_OFS)) begin
         v[`MISC_USB_TX_EN_BIT] = s.usb_en;
      end
      if (addr_hit(a, `CONVERTER_CTRL_OFS)) begin
         v[`CONV_CHAN_MSB:`CONV_CHAN_LSB] = s.chan;
         v[`CONV_EN_BIT]                  = s.conv_en;
      end
      if (addr_hit(a, `PIN_LEVEL_OFS)) begin
         v[7:0] = pins;
      end
      read_value = v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Pin input synchronisation

   pin_sync u_sync (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .d       (pad_in),
      .q       (pins_sync)
   );

   assign pin_level = pins_sync;

   ////////////////////////////////////////////////////////////////////////
   // Register file over AHB-Lite

   assign take      = hsel & htrans[1] & hready;
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st_reg.rdata;

   always_comb begin
      st_next       = st_reg;
      st_next.phase = BUS_IDLE;
      if (st_reg.phase == BUS_WRITE) begin
         case (st_reg.wr_addr)
            `PORT_DATA_LATCH_OFS: begin
               st_next.latch = hwdata[7:0];
            end
            `PORT_DIRECTION_OFS: begin
               st_next.dir = hwdata[7:0];
            end
            `EXT_IRQ_ENABLE1_OFS: begin
               st_next.irq_en = hwdata[3:0];
            end
            `MISC_CTRL_OFS: begin
               st_next.usb_en = hwdata[`MISC_USB_TX_EN_BIT];
            end
            `CONVERTER_CTRL_OFS: begin
               st_next.chan    = hwdata[`CONV_CHAN_MSB:`CONV_CHAN_LSB];
               st_next.conv_en = hwdata[`CONV_EN_BIT];
            end
            default: begin
               st_next.latch = st_reg.latch;
            end
         endcase
      end
      if (take) begin
         st_next.wr_addr = haddr[7:0];
         if (hwrite) begin
            st_next.phase = BUS_WRITE;
         end else begin
            st_next.rdata = read_value(haddr[7:0], st_next, pins_sync);
         end
      end
   end

   // zero reset leaves all pins inputs
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg         <= '0;
         st_reg.latch   <= `PORT_RESET_VAL;
         st_reg.dir     <= `PORT_RESET_VAL;
         st_reg.irq_en  <= `IRQ_EN_RESET_VAL;
         st_reg.chan    <= `CHAN_RESET_VAL;
         st_reg.phase   <= BUS_IDLE;
      end else begin
         st_reg <= st_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Pad drive and alternate functions

   assign out_mode = st_reg.dir | alt_out_en | {7'h00, st_reg.usb_en};

   for (genvar i = 0; i < 8; i++) begin : g_pad
      logic usb_here;
      assign usb_here = (i == 0) && st_reg.usb_en;
      assign pad_oe[i]  = usb_here      ? 1'b1 :
                          alt_out_en[i] ? (alt_open_drain[i] ? ~alt_out[i] : 1'b1) :
                          st_reg.dir[i];
      assign pad_out[i] = usb_here      ? usb_tx_active :
                          alt_out_en[i] ? (alt_open_drain[i] ? 1'b0 : alt_out[i]) :
                          st_reg.latch[i];
      assign analog_switch[i] = st_reg.conv_en & (st_reg.chan == 3'(i)) & ~out_mode[i];
   end

   ////////////////////////////////////////////////////////////////////////
   // External interrupt group

   assign irq_en_eff = st_reg.irq_en & ~out_mode[3:0];

   irq_group #(
      .RISE_MASK (`IRQ_GROUP_RISE_MASK)
   ) u_irq (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .lvl     (pins_sync[3:0]),
      .en      (irq_en_eff),
      .irq     (ext_irq_request)
   );

   ////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_read_latch;
      take && !hwrite && addr_hit(haddr[7:0], `PORT_DATA_LATCH_OFS)
         && st_reg.phase == BUS_IDLE;
   endsequence

   sequence s_write_latch;
      take && hwrite && addr_hit(haddr[7:0], `PORT_DATA_LATCH_OFS);
   endsequence

   sequence s_read_dir;
      take && !hwrite && addr_hit(haddr[7:0], `PORT_DIRECTION_OFS)
         && st_reg.phase == BUS_IDLE;
   endsequence

   sequence s_write_dir;
      take && hwrite && addr_hit(haddr[7:0], `PORT_DIRECTION_OFS);
   endsequence

   sequence s_read_level;
      take && !hwrite && addr_hit(haddr[7:0], `PIN_LEVEL_OFS);
   endsequence

   chk_dir_sets_oe: assert property (
      ((pad_oe ^ st_reg.dir) & ~alt_out_en & ~{7'h00, st_reg.usb_en}) == 8'h00)
      else $error("pad enable differs from direction register");

   chk_read_input_pin: assert property (
      s_read_latch |=> ((hrdata[7:0] & ~st_reg.dir) == ($past(pins_sync) & ~st_reg.dir)))
      else $error("input pin readback wrong");

   chk_read_out_latch: assert property (
      s_read_latch |=> ((hrdata[7:0] & st_reg.dir) == (st_reg.latch & st_reg.dir)))
      else $error("output pin readback wrong");

   chk_latch_write: assert property (
      s_write_latch ##1 1'b1 |=> st_reg.latch == $past(hwdata[7:0]))
      else $error("latch not updated by write");

   chk_no_out_irq: assert property (
      ext_irq_request |-> |$past(irq_en_eff))
      else $error("request without enabled input line");

   chk_fall_irq: assert property (
      (irq_en_eff == 4'h1 && $past(irq_en_eff) == 4'h1 && $fell(pins_sync[0]))
         |=> ext_irq_request)
      else $error("falling edge on enabled line lost");

   chk_group_mask: assert property (
      (irq_en_eff == 4'h3 && $past(irq_en_eff) == 4'h3 && !pins_sync[1]
         && !$past(pins_sync[1]) && $fell(pins_sync[0])) |=> !ext_irq_request)
      else $error("masked line produced request");

   chk_alt_push_pull: assert property (
      ((alt_out_en & ~alt_open_drain & ~{7'h00, st_reg.usb_en}) & ~pad_oe) == 8'h00)
      else $error("peripheral output not forced to drive");

   chk_usb_pin0: assert property (
      st_reg.usb_en |-> pad_oe[0] && pad_out[0] == usb_tx_active)
      else $error("usb transmit enable not on pin 0");

   chk_analog_route: assert property (
      (st_reg.conv_en && !out_mode[st_reg.chan]) |->
         analog_switch == (8'h01 << st_reg.chan))
      else $error("analog channel routed to wrong pin");

   chk_out_drives_latch: assert property (
      ((st_reg.dir & ~alt_out_en & ~{7'h00, st_reg.usb_en}) & (pad_out ^ st_reg.latch))
         == 8'h00)
      else $error("output pin not driven from latch");

   chk_alt_value_wins: assert property (
      ((alt_out_en & ~alt_open_drain & ~{7'h00, st_reg.usb_en}) & (pad_out ^ alt_out))
         == 8'h00)
      else $error("peripheral value not on pin");

   chk_alt_open_drain: assert property (
      ((alt_out_en & alt_open_drain & ~{7'h00, st_reg.usb_en})
         & ((pad_oe ^ ~alt_out) | pad_out)) == 8'h00)
      else $error("open drain pin drive wrong");

   chk_sync_two_stages: assert property (
      $changed(pin_level) |-> pin_level == $past(pad_in, 2))
      else $error("pin level not two stages behind pad");

   chk_level_reg_read: assert property (
      s_read_level |=> hrdata[7:0] == $past(pins_sync))
      else $error("pin level register readback wrong");

   chk_dir_readback: assert property (
      s_read_dir |=> hrdata[7:0] == st_reg.dir)
      else $error("direction readback wrong");

   chk_dir_write: assert property (
      s_write_dir ##1 1'b1 |=> st_reg.dir == $past(hwdata[7:0]))
      else $error("direction not updated by write");

   chk_analog_not_out: assert property (
      (analog_switch & out_mode) == 8'h00)
      else $error("analog switch closed on output pin");

   chk_irq_one_cycle: assert property (
      ext_irq_request |=> !ext_irq_request)
      else $error("request longer than one cycle");

   chk_quiet_no_enable: assert property (
      (irq_en_eff == 4'h0 && $past(irq_en_eff) == 4'h0) |=> !ext_irq_request)
      else $error("request with no enabled input line");

endmodule

`default_nettype wire

// File: gpio_port_map.svh
/*
 * Register offsets, field positions, reset values for the port block.
 * Assumes inclusion by bare name from files compiled after it.
 */
`ifndef GPIO_PORT_MAP_SVH
`define GPIO_PORT_MAP_SVH

`define PORT_DATA_LATCH_OFS   8'h00
`define PORT_DIRECTION_OFS    8'h04
`define EXT_IRQ_ENABLE1_OFS   8'h08
`define MISC_CTRL_OFS         8'h0C
`define CONVERTER_CTRL_OFS    8'h10
`define PIN_LEVEL_OFS         8'h14

`define PORT_RESET_VAL        8'h00
`define IRQ_EN_RESET_VAL      4'h0
`define CHAN_RESET_VAL        3'h0

`define MISC_USB_TX_EN_BIT    1
`define CONV_CHAN_LSB         0
`define CONV_CHAN_MSB         2
`define CONV_EN_BIT           3
`define IRQ_GROUP_PIN_COUNT   4
`define IRQ_GROUP_RISE_MASK   4'h0

`endif

// File: gpio_port_pkg.sv
/*
 * Types shared by the port block and its helper modules.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpio_port_pkg;

   typedef logic [7:0] byte_t;

   typedef enum {BUS_IDLE, BUS_WRITE} bus_phase_t;

   typedef struct packed {
      byte_t       latch;
      byte_t       dir;
      logic [3:0]  irq_en;
      logic        usb_en;
      logic [2:0]  chan;
      logic        conv_en;
      bus_phase_t  phase;
      logic [7:0]  wr_addr;
      logic [31:0] rdata;
   } port_state_t;

   typedef struct packed {
      byte_t s1;
      byte_t s2;
   } sync_state_t;

   typedef struct packed {
      logic comb_q;
      logic pulse;
   } irq_state_t;

endpackage

// File: pin_sync.sv
/*
 * Two-stage synchroniser for the eight pad inputs.
 * Assumes pad levels may change at any time relative to mclk.
 */
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
   input  wire logic               mclk,
   input  wire logic               sys_rst,
   input  wire gpio_port_pkg::byte_t d,
   output gpio_port_pkg::byte_t    q
);
   import gpio_port_pkg::*;

   sync_state_t st_reg;
   sync_state_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;

endmodule

`default_nettype wire

// File: irq_group.sv
/*
 * One external interrupt group: enabled lines are combined by an
 * inverted AND and a rising combined level gives a one-cycle request.
 * Assumes synchronised pin levels and enables already masked by mode.
 */
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_map.svh"

module irq_group #(
   parameter logic [3:0] RISE_MASK = `IRQ_GROUP_RISE_MASK
) (
   input  wire logic       mclk,
   input  wire logic       sys_rst,
   input  wire logic [3:0] lvl,
   input  wire logic [3:0] en,
   output logic            irq
);
   import gpio_port_pkg::*;

   irq_state_t st_reg;
   irq_state_t st_next;
   logic       comb;

   // Lines in RISE_MASK are inverted so every line is active low here
   assign comb = ~&((lvl ^ RISE_MASK) | ~en);

   always_comb begin
      st_next        = st_reg;
      st_next.comb_q = comb;
      st_next.pulse  = comb & ~st_reg.comb_q;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign irq = st_reg.pulse;

endmodule

`default_nettype wire

// File: pad_world.sv
/*
 * Pad and board model for the port block: resolves each pad from the
 * block's drive and an external source set by the bench.
 * Assumes the bench drives ext_en and ext_val from the mclk domain.
 */
`timescale 1ns/10ps
`default_nettype none

module pad_world (
   input  wire logic                 mclk,
   input  wire gpio_port_pkg::byte_t pad_out,
   input  wire gpio_port_pkg::byte_t pad_oe,
   input  wire gpio_port_pkg::byte_t ext_en,
   input  wire gpio_port_pkg::byte_t ext_val,
   output gpio_port_pkg::byte_t      pad_in
);
   import gpio_port_pkg::*;

   byte_t float_q = 8'h00;

   ////////////////////////////////////////////////////////////////////////
   // Undriven pads show a level that changes every cycle
   always_ff @(posedge mclk) begin
      float_q <= ~pad_in;
   end

   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & float_q)));
endmodule

`default_nettype wire

// File: gpio_port_test.sv
/*
 * Self-checking bench for gpio_port: AHB-Lite master tasks, one task
 * per scenario, pad model on the far side.
 * Assumes the design files and pad_world are compiled before it.
 */
`timescale 1ns/10ps
`default_nettype none

`include "gpio_port_map.svh"

module gpio_port_test;
   import gpio_port_pkg::*;

   logic        mclk, sys_rst, hsel, hwrite, hreadyout, hresp;
   logic        usb_tx_active, ext_irq_request;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   byte_t       pad_in, pad_out, pad_oe, alt_out_en, alt_out, alt_open_drain;
   byte_t       pin_level, analog_switch, ext_en, ext_val;
   int          bad_count = 0;
   int          checks_done = 0;
   int          pulses = 0;
   int          p0;

   gpio_port u_dut (.mclk(mclk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe), .alt_out_en(alt_out_en),
      .alt_out(alt_out), .alt_open_drain(alt_open_drain),
      .usb_tx_active(usb_tx_active), .pin_level(pin_level),
      .analog_switch(analog_switch), .ext_irq_request(ext_irq_request));

   pad_world u_pads (.mclk(mclk), .pad_out(pad_out), .pad_oe(pad_oe),
      .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

   ////////////////////////////////////////////////////////////////////////
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      if (ext_irq_request === 1'b1) pulses <= pulses + 1;
   end

   task automatic give_verdict;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s", $time, what);
      end
   endtask

   // One single-word transfer; read data taken at the data-phase edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge mclk);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask

   task automatic reg_rd(input logic [7:0] a);
      bus(1'b0, a, 32'h00000000);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge mclk);
   endtask

   task automatic set_pins(input byte_t v);
      @(posedge mclk);
      ext_val <= v;
      idle(6);
   endtask

   ////////////////////////////////////////////////////////////////////////
   task automatic test_reset;
      logic [7:0] offs[4];
      offs = '{`EXT_IRQ_ENABLE1_OFS, `MISC_CTRL_OFS, `CONVERTER_CTRL_OFS, 8'h18};
      foreach (offs[i]) begin
         reg_rd(offs[i]);
         check(rd, 32'h0, "register not zero after reset");
      end
      reg_rd(`PORT_DIRECTION_OFS);
      check(rd, 32'h0, "direction not zero after reset");
      check(32'(hresp), 32'h0, "response not OKAY");
      reg_wr(`PORT_DIRECTION_OFS, 32'hFF);
      reg_rd(`PORT_DATA_LATCH_OFS);
      check(rd, 32'h0, "latch not zero after reset");
      reg_wr(`PORT_DIRECTION_OFS, 32'h0);
   endtask

   task automatic test_dir_data;
      set_pins(8'hA5);
      reg_rd(`PORT_DATA_LATCH_OFS);
      check(rd, 32'hA5, "input read not pin level");
      reg_wr(`PORT_DATA_LATCH_OFS, 32'h3C);
      reg_rd(`PORT_DATA_LATCH_OFS);
      check(rd, 32'hA5, "input read after latch write");
      reg_wr(`PORT_DIRECTION_OFS, 32'hF0);
      idle(1);
      check(32'(pad_oe), 32'hF0, "enables not per bit");
      check(32'(pad_out & 8'hF0), 32'h30, "stored latch not driven");
      reg_rd(`PORT_DATA_LATCH_OFS);
      check(rd, 32'h35, "mixed direction read");
      reg_rd(`PIN_LEVEL_OFS);
      check(rd, 32'h35, "pin level register");
      reg_wr(`PORT_DIRECTION_OFS, 32'h0);
   endtask

   task automatic test_irq;
      set_pins(8'hFF);
      reg_wr(`EXT_IRQ_ENABLE1_OFS, 32'h1);
      idle(4);
      p0 = pulses;
      set_pins(8'hFE);
      check(pulses - p0, 1, "falling edge gave no request");
      set_pins(8'hFF);
      check(pulses - p0, 1, "rising edge gave a request");
      set_pins(8'hFE);
      reg_wr(`EXT_IRQ_ENABLE1_OFS, 32'h3);
      set_pins(8'hFC);
      check(pulses - p0, 2, "second line not masked");
      set_pins(8'hFD);
      set_pins(8'hFC);
      check(pulses - p0, 2, "first line not masked");
      set_pins(8'hFF);
      set_pins(8'hFD);
      check(pulses - p0, 3, "line two alone gave no request");
      reg_wr(`EXT_IRQ_ENABLE1_OFS, 32'h1);
      reg_wr(`PORT_DATA_LATCH_OFS, 32'h0);
      reg_wr(`PORT_DIRECTION_OFS, 32'h1);
      reg_wr(`PORT_DATA_LATCH_OFS, 32'h1);
      reg_wr(`PORT_DATA_LATCH_OFS, 32'h0);
      idle(6);
      check(pulses - p0, 3, "output pin gave a request");
      reg_wr(`EXT_IRQ_ENABLE1_OFS, 32'h0);
      reg_wr(`PORT_DIRECTION_OFS, 32'h0);
   endtask

   // interrupts disabled before peripherals claim pins
   task automatic test_alt;
      @(posedge mclk);
      alt_out_en <= 8'h60;
      alt_out <= 8'h20;
      alt_open_drain <= 8'h40;
      idle(1);
      check(32'(pad_oe), 32'h60, "peripheral output not forced");
      check(32'(pad_out & 8'h60), 32'h20, "peripheral value not driven");
      alt_out <= 8'h60;
      idle(1);
      check(32'(pad_oe), 32'h20, "open drain high still driven");
      alt_out_en <= 8'h00;
      // peripheral input pin left as input
      set_pins(8'hEF);
      reg_rd(`PORT_DATA_LATCH_OFS);
      check(rd & 32'h10, 32'h0, "peripheral input not readable");
      check(32'(pin_level), 32'hEF, "pin level output");
   endtask

   task automatic test_usb;
      reg_wr(`MISC_CTRL_OFS, 32'h2);
      usb_tx_active <= 1'b1;
      alt_out_en <= 8'h01;
      alt_out <= 8'h00;
      idle(1);
      check(32'(pad_oe & pad_out & 8'h01), 32'h1, "transmit enable not out");
      usb_tx_active <= 1'b0;
      idle(1);
      check(32'(pad_out & 8'h01), 32'h0, "transmit enable stuck");
      reg_wr(`MISC_CTRL_OFS, 32'h0);
      alt_out_en <= 8'h00;
   endtask

   task automatic test_analog;
      for (int c = 0; c < 8; c++) begin
         reg_wr(`CONVERTER_CTRL_OFS, 32'h8 | 32'(c));
         idle(1);
         check(32'(analog_switch), 32'h1 << c, "wrong channel switch");
      end
      reg_wr(`PORT_DIRECTION_OFS, 32'h80);
      idle(1);
      check(32'(analog_switch), 32'h0, "switch on output pin");
      reg_wr(`PORT_DIRECTION_OFS, 32'h0);
      reg_wr(`CONVERTER_CTRL_OFS, 32'h0);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      sys_rst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      usb_tx_active = 1'b0;
      alt_out_en = 8'h00;
      alt_out = 8'h00;
      alt_open_drain = 8'h00;
      ext_en = 8'hFF;
      ext_val = 8'hFF;
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      test_reset;
      test_dir_data;
      test_irq;
      test_alt;
      test_usb;
      test_analog;
      give_verdict;
   end

   // Whole run needs well under 2000 cycles
   initial begin
      #200000;
      bad_count++;
      give_verdict;
   end
endmodule

`default_nettype wire
